// ---- hdl/expiry_counter.sv ----
// 24-bit reloading down-counter with expiry pulse
`timescale 1ns/1ps
module expiry_counter #(
  parameter int WIDTH = wdt_pkg::COUNT_W
) (
  input wire logic mclk_in, // System clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic tick_in, // Time-base tick enable
  input wire logic run_in, // Countdown enabled
  input wire logic restart_in, // Load reload value now
  input wire logic [WIDTH-1:0] reload_in, // Reload value
  output logic [WIDTH-1:0] count_out, // Current count
  output logic expire_out // One-cycle expiry pulse
);

  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("expiry_counter: WIDTH must be 2..32");
  end

  logic [WIDTH-1:0] count_ff;
  logic expire_ff;
  wire step_w = tick_in && run_in && !restart_in;
  // Reaching zero on this tick, or already at zero, is an expiry
  wire hit_w = step_w && (count_ff <= WIDTH'(1));
  wire [WIDTH-1:0] nxt_count = restart_in ? reload_in :
                               hit_w ? reload_in :
                               step_w ? count_ff - WIDTH'(1) : count_ff;

  // Restart beats the tick so a strobe never loses to an expiry
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count_ff <= WIDTH'(wdt_pkg::RST_COUNT);
      expire_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      expire_ff <= hit_w;
    end
  end

  assign count_out = count_ff;
  assign expire_out = expire_ff;

endmodule : expiry_counter

// ---- hdl/tick_divider.sv ----
// Fractional divider producing the time-base tick enable
`timescale 1ns/1ps
module tick_divider #(
  parameter int CLK_HZ = wdt_pkg::CLK_HZ,
  parameter int TICK_HZ = wdt_pkg::TICK_HZ
) (
  input wire logic mclk_in, // System clock
  input wire logic rst_in, // Synchronous reset, high
  output logic tick_out // One-cycle tick enable
);

  // Rates that cannot be divided are refused
  if (TICK_HZ <= 0 || TICK_HZ >= CLK_HZ) begin : g_bad_rate
    $error("tick_divider: TICK_HZ must lie between 1 and CLK_HZ-1");
  end

  logic [31:0] acc_ff;
  logic tick_ff;
  wire [32:0] sum_w = {1'b0, acc_ff} + 33'(TICK_HZ);
  wire wrap_w = sum_w >= 33'(CLK_HZ);
  // Phase accumulator: the clock is no integer multiple of the tick, so keep the remainder
  wire [31:0] nxt_acc = wrap_w ? 32'(sum_w - 33'(CLK_HZ)) : sum_w[31:0];

  // Accumulate and flag each wrap
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      acc_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= wrap_w;
    end
  end

  assign tick_out = tick_ff;

endmodule : tick_divider

// ---- hdl/two_stage_expiry_watchdog.sv ----
// Two-stage watchdog: byte I/O registers, flags, interrupt and module reset
`timescale 1ns/1ps
module two_stage_expiry_watchdog #(
  parameter int CLK_HZ = wdt_pkg::CLK_HZ,
  parameter int TICK_HZ = wdt_pkg::TICK_HZ
) (
  input wire logic mclk_in, // System clock, 250 MHz
  input wire logic rst_in, // Synchronous reset, high
  input wire logic io_wr_in, // I/O write strobe, one cycle
  input wire logic io_rd_in, // I/O read strobe, one cycle
  input wire logic [2:0] io_addr_in, // Register offset
  input wire logic [7:0] io_wdata_in, // Write data
  input wire logic port80_wr_in, // Write seen at port 80h, one cycle
  input wire logic port80_en_in, // Port-80h strobe option enabled
  output logic [7:0] io_rdata_out, // Read data
  output logic io_rdata_valid_out, // Read data valid, one cycle
  output logic irq_out, // Interrupt request, level
  output logic module_reset_out // Module reset request, one cycle
);

  // Host cycle gathered into one carrier
  wdt_pkg::io_req_s req_w;
  assign req_w = '{wr: io_wr_in, rd: io_rd_in, addr: io_addr_in, data: io_wdata_in};

  // Register state
  logic [23:0] reload_ff;
  logic countdown_enable_ff;
  logic reset_on_expiry_enable_ff;
  logic first_expiry_flag_ff;
  logic second_expiry_flag_ff;
  logic armed_ff;
  logic irq_ff;
  logic module_reset_ff;
  logic [7:0] rdata_ff;
  logic rdata_valid_ff;

  // Counter core outputs
  logic tick_w;
  logic [23:0] count_w;
  logic expire_w;

  // Address decode
  function automatic logic hit(input wdt_pkg::io_req_s r, input logic [2:0] off);
    hit = r.wr && (r.addr == off);
  endfunction : hit

  wire wr_count_w = req_w.wr && (req_w.addr <= wdt_pkg::OFF_COUNT2);
  wire wr_rel0_w = hit(req_w, wdt_pkg::OFF_RELOAD0);
  wire wr_rel1_w = hit(req_w, wdt_pkg::OFF_RELOAD1);
  wire wr_rel2_w = hit(req_w, wdt_pkg::OFF_RELOAD2);
  wire wr_flags_w = hit(req_w, wdt_pkg::OFF_FLAGS);
  wire wr_ctrl_w = hit(req_w, wdt_pkg::OFF_CONTROL);
  wire p80_w = port80_wr_in && port80_en_in;

  // Restart sources: any count byte write, or port 80h when enabled
  wire restart_w = wr_count_w || p80_w;

  // Reload byte updates
  wire [23:0] nxt_reload = {wr_rel2_w ? req_w.data : reload_ff[23:16],
                            wr_rel1_w ? req_w.data : reload_ff[15:8],
                            wr_rel0_w ? req_w.data : reload_ff[7:0]};

  // Expiry staging: armed marks that one expiry happened since the last strobe
  wire first_evt_w = expire_w && !(armed_ff && first_expiry_flag_ff);
  wire second_evt_w = expire_w && armed_ff && first_expiry_flag_ff;
  wire clr_first_w = (wr_flags_w && req_w.data[wdt_pkg::FLAG_FIRST_BIT]) || p80_w;
  wire clr_second_w = wr_flags_w && req_w.data[wdt_pkg::FLAG_SECOND_BIT];

  // Set beats clear so a late expiry is never lost
  wire nxt_first = first_evt_w || (first_expiry_flag_ff && !clr_first_w);
  wire nxt_second = second_evt_w || (second_expiry_flag_ff && !clr_second_w);
  wire nxt_armed = expire_w || (armed_ff && !restart_w);
  wire nxt_irq = nxt_first || nxt_second;
  wire nxt_module_reset = second_evt_w && reset_on_expiry_enable_ff;

  // Read multiplexer; reserved bits read zero
  wire [7:0] flags_rd_w = {5'h00, second_expiry_flag_ff, 1'b0, first_expiry_flag_ff};
  wire [7:0] ctrl_rd_w = {6'h00, countdown_enable_ff, reset_on_expiry_enable_ff};
  wire [7:0] nxt_rdata = (req_w.addr == wdt_pkg::OFF_COUNT0) ? count_w[7:0] :
                         (req_w.addr == wdt_pkg::OFF_COUNT1) ? count_w[15:8] :
                         (req_w.addr == wdt_pkg::OFF_COUNT2) ? count_w[23:16] :
                         (req_w.addr == wdt_pkg::OFF_RELOAD0) ? reload_ff[7:0] :
                         (req_w.addr == wdt_pkg::OFF_RELOAD1) ? reload_ff[15:8] :
                         (req_w.addr == wdt_pkg::OFF_RELOAD2) ? reload_ff[23:16] :
                         (req_w.addr == wdt_pkg::OFF_FLAGS) ? flags_rd_w : ctrl_rd_w;

  // Time base
  tick_divider #(
    .CLK_HZ(CLK_HZ),
    .TICK_HZ(TICK_HZ)
  ) u_tick (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .tick_out(tick_w)
  );

  // Countdown core; only runs while the control enable is set
  expiry_counter #(
    .WIDTH(wdt_pkg::COUNT_W)
  ) u_count (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .tick_in(tick_w),
    .run_in(countdown_enable_ff),
    .restart_in(restart_w),
    .reload_in(reload_ff),
    .count_out(count_w),
    .expire_out(expire_w)
  );

  // Configuration registers; reset leaves the watchdog halted
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reload_ff <= wdt_pkg::RST_RELOAD;
      countdown_enable_ff <= 1'b0;
      reset_on_expiry_enable_ff <= 1'b0;
    end else begin
      reload_ff <= nxt_reload;
      if (wr_ctrl_w) begin
        countdown_enable_ff <= req_w.data[wdt_pkg::CTRL_COUNT_EN_BIT];
        reset_on_expiry_enable_ff <= req_w.data[wdt_pkg::CTRL_RESET_EN_BIT];
      end
    end
  end

  // Flags, interrupt and reset request
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      first_expiry_flag_ff <= 1'b0;
      second_expiry_flag_ff <= 1'b0;
      armed_ff <= 1'b0;
      irq_ff <= 1'b0;
      module_reset_ff <= 1'b0;
    end else begin
      first_expiry_flag_ff <= nxt_first;
      second_expiry_flag_ff <= nxt_second;
      armed_ff <= nxt_armed;
      irq_ff <= nxt_irq;
      module_reset_ff <= nxt_module_reset;
    end
  end

  // Registered read path, one cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_ff <= wdt_pkg::RST_BYTE;
      rdata_valid_ff <= 1'b0;
    end else begin
      rdata_ff <= req_w.rd ? nxt_rdata : wdt_pkg::RST_BYTE;
      rdata_valid_ff <= req_w.rd;
    end
  end

  assign io_rdata_out = rdata_ff;
  assign io_rdata_valid_out = rdata_valid_ff;
  assign irq_out = irq_ff;
  assign module_reset_out = module_reset_ff;

  // Checks on the countdown and flag behaviour
  a_restart_loads: assert property (@(posedge mclk_in) disable iff (rst_in)
    restart_w |=> count_w == $past(reload_ff))
    else $error("restart did not load the reload value");

  a_decrement_step: assert property (@(posedge mclk_in) disable iff (rst_in)
    (tick_w && countdown_enable_ff && !restart_w && count_w > 24'h000001) |=> count_w == $past(count_w) - 24'h000001)
    else $error("count did not step down by one on a tick");

  a_halt_holds: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!countdown_enable_ff && !restart_w) |=> $stable(count_w))
    else $error("count moved while halted");

  a_idle_no_expiry: assert property (@(posedge mclk_in) disable iff (rst_in)
    expire_w |-> $past(countdown_enable_ff) && $past(tick_w))
    else $error("expiry without an enabled tick");

  a_first_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
    (expire_w && !armed_ff) |=> first_expiry_flag_ff && irq_out)
    else $error("first expiry did not set its flag and interrupt");

  a_second_needs_first: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(second_expiry_flag_ff) |-> $past(first_expiry_flag_ff) && $past(armed_ff) && $past(expire_w))
    else $error("second flag set without a staged first expiry");

  a_reset_gated: assert property (@(posedge mclk_in) disable iff (rst_in)
    module_reset_out |-> $past(reset_on_expiry_enable_ff) && $past(second_evt_w))
    else $error("module reset without enable or second expiry");

  a_first_w1c: assert property (@(posedge mclk_in) disable iff (rst_in)
    (clr_first_w && !expire_w) |=> !first_expiry_flag_ff)
    else $error("first flag not cleared");

  a_second_w1c: assert property (@(posedge mclk_in) disable iff (rst_in)
    (clr_second_w && !expire_w) |=> !second_expiry_flag_ff)
    else $error("second flag not cleared");

  a_reserved_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    (req_w.rd && req_w.addr >= wdt_pkg::OFF_FLAGS) |=> (io_rdata_out & 8'hfa) == 8'h00 || $past(req_w.addr) == wdt_pkg::OFF_CONTROL && (io_rdata_out & 8'hfc) == 8'h00)
    else $error("reserved bits read nonzero");

  c_first_expiry: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(first_expiry_flag_ff));
  c_second_expiry: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(second_expiry_flag_ff));
  c_module_reset: cover property (@(posedge mclk_in) disable iff (rst_in) module_reset_out);
  c_port80_restart: cover property (@(posedge mclk_in) disable iff (rst_in) p80_w && armed_ff);

endmodule : two_stage_expiry_watchdog

// ---- hdl/wdt_pkg.sv ----
// Shared constants, register map and request carrier for the two-stage watchdog
package wdt_pkg;

  // Counter width and byte register offsets
  localparam int COUNT_W = 24;
  localparam logic [2:0] OFF_COUNT0 = 3'h0;
  localparam logic [2:0] OFF_COUNT1 = 3'h1;
  localparam logic [2:0] OFF_COUNT2 = 3'h2;
  localparam logic [2:0] OFF_RELOAD0 = 3'h3;
  localparam logic [2:0] OFF_RELOAD1 = 3'h4;
  localparam logic [2:0] OFF_RELOAD2 = 3'h5;
  localparam logic [2:0] OFF_FLAGS = 3'h6;
  localparam logic [2:0] OFF_CONTROL = 3'h7;

  // Field positions
  localparam int FLAG_FIRST_BIT = 0;
  localparam int FLAG_SECOND_BIT = 2;
  localparam int CTRL_RESET_EN_BIT = 0;
  localparam int CTRL_COUNT_EN_BIT = 1;

  // Reset values
  localparam logic [23:0] RST_COUNT = 24'h000000;
  localparam logic [23:0] RST_RELOAD = 24'h000000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Timing: system clock and time base rates, in hertz
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 32_768;

  // One host I/O cycle as seen by the register block
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] data;
  } io_req_s;

endpackage : wdt_pkg

// ---- test/io_host.sv ----
// Host model issuing byte I/O cycles and port-80h writes to the watchdog
`timescale 1ns/1ps
module io_host (
  input wire logic mclk_in, // System clock
  output logic io_wr_out, // Write strobe
  output logic io_rd_out, // Read strobe
  output logic [2:0] io_addr_out, // Register offset
  output logic [7:0] io_wdata_out, // Write data
  output logic port80_wr_out, // Port-80h write pulse
  input wire logic [7:0] io_rdata_in, // Read data
  input wire logic io_rdata_valid_in // Read data valid
);
  initial begin
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
    io_addr_out = 3'h0;
    io_wdata_out = 8'h00;
    port80_wr_out = 1'b0;
  end

  // Released address and data are inverted so a stale value never looks valid
  task automatic io_write(input logic [2:0] addr, input logic [7:0] data);
    @(negedge mclk_in);
    io_wr_out = 1'b1;
    io_addr_out = addr;
    io_wdata_out = data;
    @(negedge mclk_in);
    io_wr_out = 1'b0;
    io_addr_out = ~addr;
    io_wdata_out = ~data;
  endtask : io_write

  // Answer is looked for over a short bounded window
  task automatic io_read(input logic [2:0] addr, output logic [7:0] data, output logic ok);
    @(negedge mclk_in);
    io_rd_out = 1'b1;
    io_addr_out = addr;
    @(negedge mclk_in);
    io_rd_out = 1'b0;
    io_addr_out = ~addr;
    ok = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (io_rdata_valid_in === 1'b1) begin
        ok = 1'b1;
        data = io_rdata_in;
      end else begin
        @(negedge mclk_in);
      end
    end
  endtask : io_read

  task automatic port80_write();
    @(negedge mclk_in);
    port80_wr_out = 1'b1;
    @(negedge mclk_in);
    port80_wr_out = 1'b0;
  endtask : port80_write
endmodule : io_host

// ---- test/two_stage_expiry_watchdog_tb.sv ----
// Self-checking bench for the two-stage watchdog
`timescale 1ns/1ps
module two_stage_expiry_watchdog_tb;
  logic mclk_in;
  logic rst_in;
  logic port80_en;
  logic io_wr, io_rd, port80_wr, rdv, irq_out, module_reset_out, rd_ok;
  logic [2:0] io_addr;
  logic [7:0] io_wdata, rdata, rd_data;
  int failures = 0;
  int cmp_count = 0;
  int rst_pulses = 0;
  int n;
  // Short time base: one tick every 10 cycles keeps runs brief
  localparam int SIM_TICK_HZ = 25_000_000;

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // Counted mid-cycle, where the registered pulse has settled
  always @(negedge mclk_in) if (module_reset_out === 1'b1) rst_pulses++;

  two_stage_expiry_watchdog #(.TICK_HZ(SIM_TICK_HZ)) u_two_stage_expiry_watchdog (
    .mclk_in(mclk_in), .rst_in(rst_in), .io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(io_addr),
    .io_wdata_in(io_wdata), .port80_wr_in(port80_wr), .port80_en_in(port80_en), .io_rdata_out(rdata),
    .io_rdata_valid_out(rdv), .irq_out(irq_out), .module_reset_out(module_reset_out));
  io_host u_io_host (
    .mclk_in(mclk_in), .io_wr_out(io_wr), .io_rd_out(io_rd), .io_addr_out(io_addr), .io_wdata_out(io_wdata),
    .port80_wr_out(port80_wr), .io_rdata_in(rdata), .io_rdata_valid_in(rdv));

  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [2:0] addr, input logic [7:0] exp);
    u_io_host.io_read(addr, rd_data, rd_ok);
    if (rd_ok !== 1'b1) rd_data = 8'hxx;
    check(rd_data, exp);
  endtask : rd_chk

  task automatic wr(input logic [2:0] addr, input logic [7:0] data);
    u_io_host.io_write(addr, data);
  endtask : wr

  // Polls the flags register; the count of reads before the matching one is returned in n
  task automatic poll_flags(input logic [7:0] exp, input int max);
    for (n = 0; n < max; n++) begin
      u_io_host.io_read(wdt_pkg::OFF_FLAGS, rd_data, rd_ok);
      if (rd_ok === 1'b1 && rd_data === exp) return;
    end
    failures++;
    $display("Error at %0t: flags never reached %h", $time, exp);
    print_verdict();
  endtask : poll_flags

  initial begin
    rst_in = 1'b1;
    port80_en = 1'b0;
    repeat (16) @(negedge mclk_in);
    rst_in = 1'b0;
    for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
    check({6'h0, irq_out, module_reset_out}, 8'h00);
    // Halt, program reload, restart, enable
    wr(wdt_pkg::OFF_CONTROL, 8'hfc);
    rd_chk(wdt_pkg::OFF_CONTROL, 8'h00);
    for (int b = 0; b < 3; b++) wr(wdt_pkg::OFF_RELOAD0 + b[2:0], 8'h1a + 8'h11 * b[7:0]);
    for (int b = 0; b < 3; b++) rd_chk(wdt_pkg::OFF_RELOAD0 + b[2:0], 8'h1a + 8'h11 * b[7:0]);
    wr(wdt_pkg::OFF_COUNT2, 8'h99);
    for (int b = 0; b < 3; b++) rd_chk(b[2:0], 8'h1a + 8'h11 * b[7:0]);
    wr(wdt_pkg::OFF_RELOAD0, 8'h05);
    wr(wdt_pkg::OFF_RELOAD1, 8'h00);
    wr(wdt_pkg::OFF_RELOAD2, 8'h00);
    wr(wdt_pkg::OFF_COUNT0, 8'h00);
    wr(wdt_pkg::OFF_CONTROL, 8'hfe);
    rd_chk(wdt_pkg::OFF_CONTROL, 8'h02);
    // Five ticks of ten cycles; each poll costs at least two cycles
    poll_flags(8'h01, 40);
    check({7'h0, n >= 19 && n <= 25}, 8'h01);
    check({7'h0, irq_out}, 8'h01);
    poll_flags(8'h05, 40);
    check({7'h0, n >= 23 && n <= 25}, 8'h01);
    check(rst_pulses[7:0], 8'h00);
    wr(wdt_pkg::OFF_CONTROL, 8'h00);
    u_io_host.io_read(wdt_pkg::OFF_COUNT0, rd_data, rd_ok);
    n = rd_data;
    repeat (40) @(negedge mclk_in);
    rd_chk(wdt_pkg::OFF_COUNT0, n[7:0]);
    // Port-80h strobe, option off then on
    wr(wdt_pkg::OFF_RELOAD0, 8'h07);
    u_io_host.port80_write();
    rd_chk(wdt_pkg::OFF_FLAGS, 8'h05);
    port80_en = 1'b1;
    u_io_host.port80_write();
    rd_chk(wdt_pkg::OFF_FLAGS, 8'h04);
    rd_chk(wdt_pkg::OFF_COUNT0, 8'h07);
    check({7'h0, irq_out}, 8'h01);
    wr(wdt_pkg::OFF_FLAGS, 8'hfb);
    rd_chk(wdt_pkg::OFF_FLAGS, 8'h04);
    wr(wdt_pkg::OFF_FLAGS, 8'h04);
    rd_chk(wdt_pkg::OFF_FLAGS, 8'h00);
    check({7'h0, irq_out}, 8'h00);
    // Reset on second expiry enabled
    wr(wdt_pkg::OFF_COUNT1, 8'h5a);
    wr(wdt_pkg::OFF_CONTROL, 8'h03);
    poll_flags(8'h01, 50);
    check(rst_pulses[7:0], 8'h00);
    poll_flags(8'h05, 50);
    wr(wdt_pkg::OFF_CONTROL, 8'h00);
    check(rst_pulses[7:0], 8'h01);
    wr(wdt_pkg::OFF_FLAGS, 8'h01);
    rd_chk(wdt_pkg::OFF_FLAGS, 8'h04);
    wr(wdt_pkg::OFF_FLAGS, 8'h04);
    // Regular strobing keeps both stages quiet
    wr(wdt_pkg::OFF_COUNT0, 8'h00);
    wr(wdt_pkg::OFF_CONTROL, 8'h03);
    for (int s = 0; s < 10; s++) begin
      repeat (40) @(negedge mclk_in);
      u_io_host.port80_write();
    end
    rd_chk(wdt_pkg::OFF_FLAGS, 8'h00);
    check({rst_pulses[6:0], irq_out}, 8'h02);
    // Reset while running must leave it idle; no strobe follows, so a live counter would expire
    @(negedge mclk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (100) @(negedge mclk_in);
    rd_chk(wdt_pkg::OFF_CONTROL, 8'h00);
    rd_chk(wdt_pkg::OFF_COUNT0, 8'h00);
    rd_chk(wdt_pkg::OFF_FLAGS, 8'h00);
    check({rst_pulses[6:0], irq_out}, 8'h02);
    print_verdict();
  end
endmodule : two_stage_expiry_watchdog_tb
